// file: logic/chan_unit.sv
// One capture/compare channel: pin sampling, value register and output action.
`timescale 1ns/1ps
module chan_unit #(
  parameter bit IS_CH1 = 1'b0
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  ctl,
  input  wire logic        wr_lo,
  input  wire logic        wr_hi,
  input  wire logic [7:0]  wdata,
  input  wire logic [15:0] cnt,
  input  wire logic        upd,
  input  wire logic        run,
  input  wire logic        updown,
  input  wire logic        down,
  input  wire logic [15:0] period,
  input  wire logic        pin_in,
  output logic      [15:0] value,
  output logic             evt,
  output logic             pin_out,
  output logic             pin_oe_n
);
  typedef struct packed {
    logic        s0;
    logic        s1;
    logic        prev;
    logic [7:0]  lo_buf;
    logic [15:0] val;
    logic [15:0] act;
    logic        out;
    logic        oe_n;
    logic        evt;
  } chan_s;

  chan_s s_r;
  chan_s s_nxt;
  logic  rise;
  logic  fall;
  logic  hit;
  logic  m;
  logic  z;
  logic  mp;
  logic  [2:0] cmp;

  // Pin sampling, capture, buffered value writes and compare actions.
  always_comb begin
    s_nxt      = s_r;
    s_nxt.s0   = pin_in;
    s_nxt.s1   = s_r.s0;
    s_nxt.prev = s_r.s1;
    s_nxt.evt  = 1'b0;
    cmp  = ctl[timer16_pkg::CT_CMP_LSB +: 3];
    rise = s_r.s1 & ~s_r.prev;
    fall = ~s_r.s1 & s_r.prev;
    m    = upd && (cnt == s_r.act);
    z    = upd && (cnt == timer16_pkg::CNT_ZERO);
    mp   = upd && (cnt == period);
    s_nxt.oe_n = ~ctl[timer16_pkg::CT_ROLE]; // [R15]
    case (ctl[timer16_pkg::CT_EDGE_LSB +: 2])
      timer16_pkg::EDGE_RISE: hit = rise; // [R16]
      timer16_pkg::EDGE_FALL: hit = fall;
      timer16_pkg::EDGE_ANY:  hit = rise | fall;
      default:                hit = 1'b0;
    endcase
    if (!ctl[timer16_pkg::CT_ROLE]) begin
      if (hit && run) begin
        s_nxt.val = cnt; // [R20]
        s_nxt.evt = 1'b1; // [R1]
      end
    end else begin
      // Codes past toggle pick up a new value only at zero, keeping PWM glitch-free.
      if (z && cmp >= timer16_pkg::CMP_SET_UP) begin
        s_nxt.act = s_r.val;
      end
      case (cmp)
        timer16_pkg::CMP_SET: if (m) s_nxt.out = 1'b1; // [R10]
        timer16_pkg::CMP_CLR: if (m) s_nxt.out = 1'b0;
        timer16_pkg::CMP_TGL: if (m) s_nxt.out = ~s_r.out;
        timer16_pkg::CMP_SET_UP: begin
          if (m) s_nxt.out = ~(updown & down); // [R11]
          else if (z && !updown) s_nxt.out = 1'b0;
        end
        timer16_pkg::CMP_CLR_UP: begin
          if (m) s_nxt.out = updown & down; // [R12]
          else if (z && !updown) s_nxt.out = 1'b1;
        end
        timer16_pkg::CMP_PER_CLR: begin
          if (IS_CH1 && m) s_nxt.out = 1'b1; // [R13]
          else if (IS_CH1 && mp) s_nxt.out = 1'b0;
        end
        timer16_pkg::CMP_PER_SET: begin
          if (IS_CH1 && m) s_nxt.out = 1'b0; // [R13]
          else if (IS_CH1 && mp) s_nxt.out = 1'b1;
        end
        default: s_nxt.out = s_r.out; // [R14]
      endcase
      s_nxt.evt = (!IS_CH1 && updown) ? z : m; // [R21]
    end
    if (wr_lo) begin
      s_nxt.lo_buf = wdata; // [R19]
    end
    if (wr_hi) begin
      s_nxt.val = {wdata, s_r.lo_buf}; // [R18]
      if (cmp < timer16_pkg::CMP_SET_UP) begin
        s_nxt.act = {wdata, s_r.lo_buf};
      end
    end
  end

  // State register; outputs come straight from it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r      <= '0;
      s_r.oe_n <= 1'b1; // [R22]
    end else begin
      s_r <= s_nxt;
    end
  end

  assign value    = s_r.val;
  assign evt      = s_r.evt;
  assign pin_out  = s_r.out;
  assign pin_oe_n = s_r.oe_n;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  capture_copy_a: assert property (!ctl[2] && hit && run && !wr_hi |=> value == $past(cnt) && evt) // [R20]
    else $error("capture did not copy the counter");
  rise_only_a: assert property (!ctl[2] && ctl[1:0] == 2'h1 && run && fall |=> !evt) // [R16]
    else $error("falling edge captured in rising mode");
  low_held_a: assert property (ctl[2] && wr_lo && !wr_hi |=> $stable(value)) // [R19]
    else $error("low byte write changed the value early");
  // Channel 0 in up/down compare flags at zero instead of on the match.
  set_match_a: assert property (ctl[2] && cmp == 3'h0 && m
                                |=> pin_out && (evt == (($past(updown) && !IS_CH1) ? $past(z) : 1'b1))) // [R10]
    else $error("compare set action missed");
  role_drive_a: assert property (ctl[2] |=> !pin_oe_n) // [R15]
    else $error("compare role does not drive the pin");
endmodule

// file: logic/timer16_ctrl.sv
// Timer control, status, prescaler, counter and channel 0/1 set-up behind APB.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module timer16_ctrl (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [timer16_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                    pwdata,
  input  wire logic [3:0]                     pstrb,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           chan2_event,
  input  wire logic [1:0]                     chan_pin_in,
  output logic      [1:0]                     chan_pin_out,
  output logic      [1:0]                     chan_pin_oe_n,
  output logic      [1:0]                     chan_irq,
  output logic                                terminal_count_flag,
  output logic                                chan2_flag
);
  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [6:0]        pre;
    logic [15:0]       cnt;
    timer16_pkg::dir_e dir;
    logic              upd;
    logic [3:0]        flags;
    logic [1:0]        div;
    logic [1:0]        mode;
    logic [7:0]        ctl0;
    logic [7:0]        ctl1;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    logic [1:0]        irq;
  } ctrl_s;

  ctrl_s       s_r;
  ctrl_s       s_nxt;
  logic [7:0]  idx;
  logic        hit;
  logic        we;
  logic        we_st;
  logic        tick;
  logic        ovf_set;
  logic [6:0]  pre_lim;
  logic [31:0] rd;
  logic [3:0]  set_v;
  logic [15:0] period;
  logic [15:0] val_w [2];
  logic [1:0]  evt_w;
  logic [1:0]  wr_lo;
  logic [1:0]  wr_hi;
  logic [7:0]  ctl_w [2];

  // ==========================================================
  // Bus decode
  // ==========================================================
  // A write lands on the edge at which pready is already high, so the
  // registers never see a half-finished transfer.
  always_comb begin
    idx = paddr[timer16_pkg::ADDR_W-1:2];
    case (idx)
      timer16_pkg::IDX_CH0_LO,
      timer16_pkg::IDX_CH0_HI,
      timer16_pkg::IDX_CH1_LO,
      timer16_pkg::IDX_CH1_HI,
      timer16_pkg::IDX_STATUS,
      timer16_pkg::IDX_CTL0,
      timer16_pkg::IDX_CTL1,
      timer16_pkg::IDX_COUNT: hit = (paddr[1:0] == 2'h0);
      default:                hit = 1'b0;
    endcase
    we       = psel && penable && s_r.pready && pwrite && pstrb[0] && hit;
    we_st    = we && (idx == timer16_pkg::IDX_STATUS);
    wr_lo[0] = we && (idx == timer16_pkg::IDX_CH0_LO);
    wr_hi[0] = we && (idx == timer16_pkg::IDX_CH0_HI);
    wr_lo[1] = we && (idx == timer16_pkg::IDX_CH1_LO);
    wr_hi[1] = we && (idx == timer16_pkg::IDX_CH1_HI);
  end

  // Read data; bits above the register width read as zero.
  always_comb begin
    rd = 32'h0000_0000;
    case (idx)
      timer16_pkg::IDX_CH0_LO: rd[7:0] = val_w[0][7:0];
      timer16_pkg::IDX_CH0_HI: rd[7:0] = val_w[0][15:8];
      timer16_pkg::IDX_CH1_LO: rd[7:0] = val_w[1][7:0];
      timer16_pkg::IDX_CH1_HI: rd[7:0] = val_w[1][15:8];
      timer16_pkg::IDX_STATUS: rd[7:0] = {s_r.flags, s_r.div, s_r.mode};
      timer16_pkg::IDX_CTL0:   rd[7:0] = s_r.ctl0;
      timer16_pkg::IDX_CTL1:   rd[7:0] = s_r.ctl1;
      timer16_pkg::IDX_COUNT:  rd[15:0] = s_r.cnt;
      default:                 rd = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Prescaler
  // ==========================================================
  // The tick is pclk itself; the divider yields a one-cycle enable.
  always_comb begin
    case (s_r.div)
      2'h1:    pre_lim = timer16_pkg::PRE_8; // [R4]
      2'h2:    pre_lim = timer16_pkg::PRE_32;
      2'h3:    pre_lim = timer16_pkg::PRE_128;
      default: pre_lim = timer16_pkg::PRE_1;
    endcase
    tick = (s_r.mode != timer16_pkg::MODE_STOP) && (s_r.pre >= pre_lim); // [R5]
  end

  assign period = val_w[0];

  // ==========================================================
  // Counter, flags, configuration and bus answer
  // ==========================================================
  always_comb begin
    s_nxt     = s_r;
    s_nxt.upd = tick;
    ovf_set   = 1'b0;
    // Prescaler restarts from zero while suspended, so the first tick
    // after starting is a full divide period away.
    if (s_r.mode == timer16_pkg::MODE_STOP) begin
      s_nxt.pre = 7'h00; // [R5]
    end else if (tick) begin
      s_nxt.pre = 7'h00;
    end else begin
      s_nxt.pre = s_r.pre + 7'h01;
    end
    if (tick) begin
      case (s_r.mode)
        timer16_pkg::MODE_FREE: begin
          s_nxt.dir = timer16_pkg::DIR_UP;
          s_nxt.cnt = s_r.cnt + 16'h0001; // [R6]
          ovf_set   = (s_r.cnt == timer16_pkg::CNT_MAX); // [R3]
        end
        timer16_pkg::MODE_MOD: begin
          s_nxt.dir = timer16_pkg::DIR_UP;
          // A period written below the count restarts at once.
          if (s_r.cnt >= period) begin
            s_nxt.cnt = timer16_pkg::CNT_ZERO; // [R7]
            ovf_set   = 1'b1; // [R3]
          end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
          end
        end
        timer16_pkg::MODE_UPDN: begin
          if (s_r.dir == timer16_pkg::DIR_UP) begin
            if (s_r.cnt >= period && period != timer16_pkg::CNT_ZERO) begin
              s_nxt.dir = timer16_pkg::DIR_DOWN; // [R8]
              s_nxt.cnt = s_r.cnt - 16'h0001;
            end else if (s_r.cnt < period) begin
              s_nxt.cnt = s_r.cnt + 16'h0001;
            end
          end else if (s_r.cnt == timer16_pkg::CNT_ZERO) begin
            s_nxt.dir = timer16_pkg::DIR_UP; // [R8]
            if (period != timer16_pkg::CNT_ZERO) begin
              s_nxt.cnt = 16'h0001;
            end
          end else begin
            s_nxt.cnt = s_r.cnt - 16'h0001;
          end
        end
        default: s_nxt.cnt = s_r.cnt;
      endcase
    end
    // Hardware set beats a software clear in the same cycle.
    set_v = {chan2_event, evt_w[1], evt_w[0], ovf_set}; // [R1]
    if (we_st) begin
      s_nxt.flags = (s_r.flags & pwdata[7:4]) | set_v; // [R2]
      s_nxt.div   = pwdata[timer16_pkg::ST_DIV_LSB +: 2];
      s_nxt.mode  = pwdata[timer16_pkg::ST_MODE_LSB +: 2];
    end else begin
      s_nxt.flags = s_r.flags | set_v; // [R1]
    end
    if (we && idx == timer16_pkg::IDX_CTL0) begin
      s_nxt.ctl0 = pwdata[7:0]; // [R17]
    end
    if (we && idx == timer16_pkg::IDX_CTL1) begin
      s_nxt.ctl1 = pwdata[7:0];
    end
    // Request lines follow flag and mask, including a mask set late.
    s_nxt.irq[0] = s_r.flags[1] & s_r.ctl0[timer16_pkg::CT_MASK]; // [R9]
    s_nxt.irq[1] = s_r.flags[2] & s_r.ctl1[timer16_pkg::CT_MASK];
    // One wait state: pready rises in the second access cycle.
    s_nxt.pready  = psel && penable && !s_r.pready;
    s_nxt.pslverr = psel && penable && !s_r.pready && !hit;
    if (psel && penable && !s_r.pready) begin
      s_nxt.prdata = pwrite ? 32'h0000_0000 : rd;
    end
  end

  // Registers; everything off and both masks set after reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r      <= '0; // [R22]
      s_r.ctl0 <= timer16_pkg::CTL_RESET;
      s_r.ctl1 <= timer16_pkg::CTL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Channels
  // ==========================================================
  assign ctl_w[0] = s_r.ctl0;
  assign ctl_w[1] = s_r.ctl1;

  for (genvar g = 0; g < 2; g++) begin : g_chan
    chan_unit #(
      .IS_CH1 (g == 1)
    ) u_chan (
      .pclk     (pclk),
      .presetn  (presetn),
      .ctl      (ctl_w[g]),
      .wr_lo    (wr_lo[g]),
      .wr_hi    (wr_hi[g]),
      .wdata    (pwdata[7:0]),
      .cnt      (s_r.cnt),
      .upd      (s_r.upd),
      .run      (s_r.mode != timer16_pkg::MODE_STOP),
      .updown   (s_r.mode == timer16_pkg::MODE_UPDN),
      .down     (s_r.dir == timer16_pkg::DIR_DOWN),
      .period   (period),
      .pin_in   (chan_pin_in[g]),
      .value    (val_w[g]),
      .evt      (evt_w[g]),
      .pin_out  (chan_pin_out[g]),
      .pin_oe_n (chan_pin_oe_n[g])
    );
  end

  assign prdata              = s_r.prdata;
  assign pready              = s_r.pready;
  assign pslverr             = s_r.pslverr;
  assign chan_irq            = s_r.irq;
  assign terminal_count_flag = s_r.flags[0];
  assign chan2_flag          = s_r.flags[3];

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence div8_tick_s;
    tick && s_r.div == 2'h1;
  endsequence

  sequence quiet7_s;
    (!tick)[*7];
  endsequence

  flag_set_a: assert property (evt_w[0] |=> s_r.flags[1]) // [R1]
    else $error("channel 0 event lost its flag");
  one_keeps_a: assert property (we_st && pwdata[5] && s_r.flags[1] |=> s_r.flags[1]) // [R2]
    else $error("writing one cleared a flag");
  zero_clears_a: assert property (we_st && !pwdata[5] && !evt_w[0] |=> !s_r.flags[1]) // [R2]
    else $error("writing zero left a flag set");
  free_wrap_a: assert property (tick && s_r.mode == 2'h1 && s_r.cnt == 16'hFFFF
                                |=> s_r.cnt == 16'h0000 && s_r.flags[0]) // [R3]
    else $error("free-running wrap or terminal flag wrong");
  div8_gap_a: assert property (div8_tick_s |=> quiet7_s) // [R4]
    else $error("divide by eight ticked early");
  suspend_a: assert property (s_r.mode == 2'h0 |=> $stable(s_r.cnt)) // [R5]
    else $error("counter moved while suspended");
  modulo_a: assert property (tick && s_r.mode == 2'h2 && s_r.cnt >= period
                             |=> s_r.cnt == 16'h0000 && s_r.flags[0]) // [R7]
    else $error("modulo restart missed");
  turn_down_a: assert property (tick && s_r.mode == 2'h3 && s_r.dir == timer16_pkg::DIR_UP
                                && s_r.cnt == period && period != 16'h0000
                                |=> s_r.dir == timer16_pkg::DIR_DOWN && s_r.cnt == $past(s_r.cnt) - 16'h0001) // [R8]
    else $error("up/down did not turn at the period");
  mask_gate_a: assert property (s_r.flags[2] && s_r.ctl1[6] |=> chan_irq[1]) // [R9]
    else $error("masked-in flag gave no request");
  mask_off_a: assert property (!s_r.ctl0[6] |=> !chan_irq[0]) // [R9]
    else $error("request raised with mask clear");
  ud_zero_a: assert property (s_r.upd && s_r.mode == 2'h3 && s_r.ctl0[2]
                              && s_r.cnt == 16'h0000 |=> ##1 s_r.flags[1]) // [R21]
    else $error("up/down zero did not flag channel 0");
endmodule

// file: logic/timer16_pkg.sv
// Constants, field layout and types shared by the timer files.
//
// Overview of operation
// [R1] Channel events set their sticky status flags.
// [R2] Flags clear only by writing zero.
// [R3] Terminal count sets flag in free/modulo.
// [R4] Prescaler divides tick by 1/8/32/128.
// [R5] Mode 00 suspends the counter.
// [R6] Mode 01 counts 0 to FFFF, wraps.
// [R7] Mode 10 counts 0 to channel 0 value.
// [R8] Mode 11 counts up then down repeatedly.
// [R9] Channel mask bit 6 gates interrupt request.
// [R10] Codes 000/001/010 set, clear, toggle output.
// [R11] Code 011 sets on match up, clears later.
// [R12] Code 100 clears on match up, sets later.
// [R13] Channel 1 codes 101/110 use both values.
// [R14] Software avoids unused compare codes.
// [R15] Control bit 2 selects capture or compare.
// [R16] Edge field: none, rising, falling, both.
// [R17] Software writes zero to reserved bit 7.
// [R18] Channel 0 value is two bytes, reset zero.
// [R19] Low byte waits until high byte written.
// [R20] Capture edge copies counter into value.
// [R21] Up/down compare: channel 0 flags at zero.
// [R22] Reset: all off, interrupt masks set.
package timer16_pkg;
  localparam int          ADDR_W      = 10;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0]  IDX_CH0_LO  = 8'hDA;
  localparam logic [7:0]  IDX_CH0_HI  = 8'hDB;
  localparam logic [7:0]  IDX_CH1_LO  = 8'hDC;
  localparam logic [7:0]  IDX_CH1_HI  = 8'hDD;
  localparam logic [7:0]  IDX_STATUS  = 8'hE4;
  localparam logic [7:0]  IDX_CTL0    = 8'hE5;
  localparam logic [7:0]  IDX_CTL1    = 8'hE6;
  localparam logic [7:0]  IDX_COUNT   = 8'hF0;
  // Status register fields.
  localparam int          ST_FLAG_LSB = 4;
  localparam int          ST_DIV_LSB  = 2;
  localparam int          ST_MODE_LSB = 0;
  // Channel control fields.
  localparam int          CT_MASK     = 6;
  localparam int          CT_CMP_LSB  = 3;
  localparam int          CT_ROLE     = 2;
  localparam int          CT_EDGE_LSB = 0;
  localparam logic [7:0]  CTL_RESET   = 8'h40;
  localparam logic [15:0] VAL_RESET   = 16'h0000;
  // Counting modes.
  localparam logic [1:0]  MODE_STOP   = 2'h0;
  localparam logic [1:0]  MODE_FREE   = 2'h1;
  localparam logic [1:0]  MODE_MOD    = 2'h2;
  localparam logic [1:0]  MODE_UPDN   = 2'h3;
  // Prescaler terminal counts for divide by 1, 8, 32 and 128.
  localparam logic [6:0]  PRE_1       = 7'h00;
  localparam logic [6:0]  PRE_8       = 7'h07;
  localparam logic [6:0]  PRE_32      = 7'h1F;
  localparam logic [6:0]  PRE_128     = 7'h7F;
  // Compare actions.
  localparam logic [2:0]  CMP_SET     = 3'h0;
  localparam logic [2:0]  CMP_CLR     = 3'h1;
  localparam logic [2:0]  CMP_TGL     = 3'h2;
  localparam logic [2:0]  CMP_SET_UP  = 3'h3;
  localparam logic [2:0]  CMP_CLR_UP  = 3'h4;
  localparam logic [2:0]  CMP_PER_CLR = 3'h5;
  localparam logic [2:0]  CMP_PER_SET = 3'h6;
  // Capture edge selections.
  localparam logic [1:0]  EDGE_NONE   = 2'h0;
  localparam logic [1:0]  EDGE_RISE   = 2'h1;
  localparam logic [1:0]  EDGE_FALL   = 2'h2;
  localparam logic [1:0]  EDGE_ANY    = 2'h3;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO    = 16'h0000;

  typedef enum logic {DIR_UP, DIR_DOWN} dir_e;
endpackage

// file: verif/pin_partner.sv
// Far-side model of the two channel pins: capture sources and compare loads.
`timescale 1ns/1ps
module pin_partner (
  input  wire logic [1:0] drive,
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe_n,
  output logic      [1:0] pin_in
);
  // ==========================================================
  // Wire resolution
  // A pin in compare role is driven by the block, so the source lets go of it.
  assign pin_in[0] = pin_oe_n[0] ? drive[0] : pin_out[0];
  assign pin_in[1] = pin_oe_n[1] ? drive[1] : pin_out[1];
endmodule

// file: verif/testbench.sv
// Self-checking bench for the timer control and channel set-up block.
`timescale 1ns/1ps
module testbench;
  logic                           pclk;
  logic                           presetn;
  logic                           psel;
  logic                           penable;
  logic                           pwrite;
  logic [timer16_pkg::ADDR_W-1:0] paddr;
  logic [31:0]                    pwdata;
  logic [3:0]                     pstrb;
  logic [31:0]                    prdata;
  logic                           pready;
  logic                           pslverr;
  logic                           chan2_event;
  logic [1:0]                     pin_in;
  logic [1:0]                     pin_out;
  logic [1:0]                     pin_oe_n;
  logic [1:0]                     chan_irq;
  logic                           tc_flag;
  logic                           c2_flag;
  logic [1:0]                     drive;
  logic [31:0]                    rd;
  logic [31:0]                    c1;
  logic [31:0]                    prev;
  logic [31:0]                    top;
  logic                           down;
  logic                           err;
  int                             errors;
  int                             comparisons;
  int                             cycles;

  timer16_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan2_event(chan2_event), .chan_pin_in(pin_in), .chan_pin_out(pin_out), .chan_pin_oe_n(pin_oe_n),
    .chan_irq(chan_irq), .terminal_count_flag(tc_flag), .chan2_flag(c2_flag));

  pin_partner far_side (.drive(drive), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));

  // ==========================================================
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // The whole run needs about 360 cycles, so a much larger ceiling marks a hang.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic give_verdict();
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; entered just after a rising edge, leaves one idle cycle behind it.
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    pstrb   <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    xfer(1'b1, idx, wd);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 8'h00);
    check(rd, exp);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    chan2_event = 1'b0;
    drive = 2'b00;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset state: suspended, masks set, values zero, pins released.
    rdchk(timer16_pkg::IDX_STATUS, 32'h00000000);
    rdchk(timer16_pkg::IDX_CTL0, 32'h00000040);
    rdchk(timer16_pkg::IDX_CTL1, 32'h00000040);
    rdchk(timer16_pkg::IDX_CH0_LO, 32'h00000000);
    rdchk(timer16_pkg::IDX_CH0_HI, 32'h00000000);
    check({30'h0, pin_oe_n}, 32'h00000003);
    xfer(1'b0, 8'h00, 8'h00);
    check({31'h0, err}, 32'h00000001);
    // Only the low byte of the period is written, so modulo must still hold at zero.
    wr(timer16_pkg::IDX_CH0_LO, 8'h05);
    wr(timer16_pkg::IDX_CTL1, 8'h41);
    wr(timer16_pkg::IDX_CTL0, 8'h44);
    wr(timer16_pkg::IDX_STATUS, 8'h02);
    repeat (10) @(posedge pclk);
    rdchk(timer16_pkg::IDX_COUNT, 32'h00000000);
    wr(timer16_pkg::IDX_CH0_HI, 8'h00);
    rdchk(timer16_pkg::IDX_CH0_LO, 32'h00000005);
    repeat (20) @(posedge pclk);
    xfer(1'b0, timer16_pkg::IDX_COUNT, 8'h00);
    check({31'h0, rd <= 32'h5}, 32'h00000001);
    check({30'h0, pin_out}, 32'h00000001);
    check({31'h0, pin_in[0]}, 32'h00000001);
    wr(timer16_pkg::IDX_CTL0, 8'h4C);
    repeat (20) @(posedge pclk);
    check({31'h0, pin_out[0]}, 32'h00000000);
    // Slow prescaler so a capture lands inside one counter step; flags written as ones stay.
    wr(timer16_pkg::IDX_STATUS, 8'hFE);
    xfer(1'b0, timer16_pkg::IDX_COUNT, 8'h00);
    c1 = rd;
    drive <= 2'b10;
    repeat (8) @(posedge pclk);
    xfer(1'b0, timer16_pkg::IDX_COUNT, 8'h00);
    check(rd, c1);
    if (rd === c1) begin
      rdchk(timer16_pkg::IDX_CH1_LO, c1 & 32'hFF);
      rdchk(timer16_pkg::IDX_CH1_HI, c1 >> 8);
    end
    check({31'h0, chan_irq[1]}, 32'h00000001);
    chan2_event <= 1'b1;
    @(posedge pclk);
    chan2_event <= 1'b0;
    @(posedge pclk);
    // Writing ones to the flags keeps them while the timer is stopped.
    wr(timer16_pkg::IDX_STATUS, 8'hF0);
    rdchk(timer16_pkg::IDX_STATUS, 32'h000000F0);
    check({30'h0, c2_flag, tc_flag}, 32'h00000003);
    xfer(1'b0, timer16_pkg::IDX_COUNT, 8'h00);
    c1 = rd;
    repeat (20) @(posedge pclk);
    rdchk(timer16_pkg::IDX_COUNT, c1);
    wr(timer16_pkg::IDX_STATUS, 8'h00);
    rdchk(timer16_pkg::IDX_STATUS, 32'h00000000);
    check({30'h0, chan_irq}, 32'h00000000);
    // Up/down at divide by 8: reads come faster than steps, so a one-step fall is seen.
    wr(timer16_pkg::IDX_STATUS, 8'h07);
    prev = 0;
    top = 0;
    down = 1'b0;
    for (int i = 0; i < 40; i++) begin
      xfer(1'b0, timer16_pkg::IDX_COUNT, 8'h00);
      if (rd > top) top = rd;
      if (prev - rd == 32'h1) down = 1'b1;
      prev = rd;
    end
    check(top, 32'h00000005);
    check({31'h0, down}, 32'h00000001);
    give_verdict();
  end
endmodule
